// *** verilog/dbs_sram_ctl.sv ***
// Controller end of the link with an Avalon-MM register slave
`timescale 1ns/1ps
module dbs_sram_ctl
  import dbs_pkg::*;
#(
  parameter int AW       = DBS_AW,
  parameter int HALF_DIV = DBS_HALF_DIV
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // Link
  dbs_link_if.ctl          link,
  // Avalon-MM slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);

  localparam int DW = DBS_DW;
  localparam int VW = $clog2(HALF_DIV);
  localparam logic [VW-1:0] DIV_LAST  = VW'(HALF_DIV - 1);
  localparam logic [VW-1:0] DIV_MID   = VW'(HALF_DIV / 2 - 1);
  localparam logic [11:0]   LOCK_LAST = 12'(DBS_LOCK_CYC - 1);

  typedef struct packed {
    dbs_ctl_st_t        st;
    logic [VW-1:0]      div;
    logic [11:0]        lock;
    logic [3:0]         clk;
    logic [3:0]         j;
    logic               load_n;
    logic               rd;
    logic [AW-1:0]      a;
    logic [1:0]         bw_n;
    logic [DW-1:0]      dq;
    logic               oe;
    logic [DW-1:0]      dq_m;
    logic [DW-1:0]      dq_s;
    logic               rd_sel;
    logic               single;
    logic               pll;
    logic               stop;
    logic [AW-1:0]      addr;
    logic [7:0]         mask;
    logic [3:0][DW-1:0] wdat;
    logic [3:0][DW-1:0] rdat;
    logic               ack;
    logic [31:0]        rdata;
  } dbs_ctl_reg_t;

  dbs_ctl_reg_t s;
  dbs_ctl_reg_t next_s;
  logic         edge_p;
  logic         mid_p;
  logic         req;
  logic [1:0]   widx;
  logic [31:0]  rmux;

  always_comb begin
    next_s = s;
    edge_p = 1'b0;
    widx   = 2'(s.j - DBS_J_WR0);
    req    = avs_read | avs_write;
    next_s.dq_m = link.shared_data_bus;
    next_s.dq_s = s.dq_m;
    if (s.div == DIV_LAST) begin
      next_s.div = '0;
      edge_p     = 1'b1;
    end else begin
      next_s.div = s.div + 1'b1;
    end
    // Pins change mid half-period so the far end never sees a race
    mid_p = (s.div == DIV_MID);

    if (edge_p) begin
      if (s.stop && s.st != DBS_RUN) begin
        next_s.clk  = '0;
        next_s.st   = DBS_LOCK;
        next_s.lock = '0;
      end else begin
        next_s.clk[DBS_PK]  = ~s.clk[DBS_PK];
        next_s.clk[DBS_PKN] = s.clk[DBS_PK];
        next_s.clk[DBS_PC]  = s.single | ~s.clk[DBS_PK];
        next_s.clk[DBS_PCN] = s.single | s.clk[DBS_PK];
      end
    end

    // No command before the clock has run long enough to lock
    if (s.st == DBS_LOCK && !s.stop) begin
      if (s.lock == LOCK_LAST) begin
        next_s.st = DBS_IDLE;
      end else begin
        next_s.lock = s.lock + 1'b1;
      end
    end

    if (s.st == DBS_RUN) begin
      if (mid_p) begin
        if (s.j == 4'h0 && !s.clk[DBS_PK]) begin
          next_s.load_n = 1'b0;
          next_s.rd     = s.rd_sel;
          next_s.a      = s.addr;
          next_s.j      = 4'h1;
        end else if (s.j == DBS_J_LOAD_END) begin
          next_s.load_n = 1'b1;
        end
        if (!s.rd && s.j >= DBS_J_WR0 && s.j < DBS_J_WR_END) begin
          next_s.dq   = s.wdat[widx];
          next_s.bw_n = s.mask[2*widx +: 2];
          next_s.oe   = 1'b1;
        end else if (s.j == DBS_J_WR_END) begin
          next_s.oe = 1'b0;
        end
      end
      if (edge_p && s.j != 4'h0) begin
        next_s.j = s.j + 1'b1;
        if (s.rd && s.j >= DBS_J_RD0) begin
          next_s.rdat[2'(s.j - DBS_J_RD0)] = s.dq_s;
        end
        if (s.j == DBS_J_END) begin
          next_s.st = DBS_IDLE;
          next_s.j  = 4'h0;
        end
      end
    end

    rmux = 32'h0000_0000;
    if (avs_address == DBS_REG_CTRL) begin
      rmux[DBS_CTRL_STOP:DBS_CTRL_RD] = {s.stop, s.pll, s.single, s.rd_sel};
    end else if (avs_address == DBS_REG_ADDR) begin
      rmux[AW-1:0] = s.addr;
    end else if (avs_address == DBS_REG_MASK) begin
      rmux[7:0] = s.mask;
    end else if (avs_address == DBS_REG_STAT) begin
      rmux[1:0] = {s.st != DBS_LOCK, s.st == DBS_RUN};
    end else if (avs_address[5:4] == DBS_WIN_WDAT) begin
      rmux[DW-1:0] = s.wdat[avs_address[3:2]];
    end else if (avs_address[5:4] == DBS_WIN_RDAT) begin
      rmux[DW-1:0] = s.rdat[avs_address[3:2]];
    end

    // One wait cycle, then the access completes
    next_s.ack = req & ~s.ack;
    if (req && !s.ack) begin
      next_s.rdata = rmux;
    end
    if (avs_write && s.ack) begin
      if (avs_address == DBS_REG_CTRL) begin
        next_s.rd_sel = avs_writedata[DBS_CTRL_RD];
        next_s.single = avs_writedata[DBS_CTRL_SINGLE];
        // Clear only when K is at or above 120 MHz is not assured
        next_s.pll    = avs_writedata[DBS_CTRL_PLL];
        next_s.stop   = avs_writedata[DBS_CTRL_STOP];
        if (avs_writedata[DBS_CTRL_GO] && s.st == DBS_IDLE && !s.stop) begin
          next_s.st = DBS_RUN;
          next_s.j  = 4'h0;
        end
      end else if (avs_address == DBS_REG_ADDR) begin
        next_s.addr = avs_writedata[AW-1:0];
      end else if (avs_address == DBS_REG_MASK) begin
        next_s.mask = avs_writedata[7:0];
      end else if (avs_address[5:4] == DBS_WIN_WDAT) begin
        next_s.wdat[avs_address[3:2]] = avs_writedata[DW-1:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s        <= '0;
      s.st     <= DBS_LOCK;
      s.load_n <= 1'b1;
      s.bw_n   <= 2'b11;
      s.pll    <= DBS_CTRL_RST[DBS_CTRL_PLL];
      s.mask   <= DBS_MASK_RST;
    end else begin
      s <= next_s;
    end
  end

  assign link.k                    = s.clk[DBS_PK];
  assign link.k_n                  = s.clk[DBS_PKN];
  assign link.c                    = s.clk[DBS_PC];
  assign link.c_n                  = s.clk[DBS_PCN];
  assign link.cycle_load_n         = s.load_n;
  assign link.read_sel             = s.rd;
  assign link.addr                 = s.a;
  assign link.low_byte_write_en_n  = s.bw_n[0];
  assign link.high_byte_write_en_n = s.bw_n[1];
  assign link.pll_disable_n        = s.pll;
  assign link.ctl_dq               = s.dq;
  assign link.ctl_dq_oe            = s.oe;
  assign avs_readdata              = s.rdata;
  assign avs_waitrequest           = req & ~s.ack;

endmodule

// *** verilog/dbs_pkg.sv ***
// Shared constants and types for the burst-of-four DDR SRAM link
package dbs_pkg;
  localparam int DBS_DW     = 18;
  localparam int DBS_AW     = 20;
  localparam int DBS_LO_MSB = 8;
  localparam int DBS_HI_LSB = 9;
  // Positions in the sampled clock vector {c_n, c, k_n, k}
  localparam int DBS_PK  = 0;
  localparam int DBS_PKN = 1;
  localparam int DBS_PC  = 2;
  localparam int DBS_PCN = 3;
  localparam int DBS_CLK_NS    = 8;
  localparam int DBS_LOCK_NS   = 20000;
  localparam int DBS_LOCK_CYC  = (DBS_LOCK_NS + DBS_CLK_NS - 1) / DBS_CLK_NS + 1;
  localparam int DBS_KSTOP_CYC = 64;
  localparam int DBS_HALF_DIV  = 8;
  // Controller schedule, in link clock edges from the load edge
  localparam logic [3:0] DBS_J_LOAD_END = 4'h2;
  localparam logic [3:0] DBS_J_WR0      = 4'h3;
  localparam logic [3:0] DBS_J_WR_END   = 4'h7;
  localparam logic [3:0] DBS_J_RD0      = 4'h5;
  localparam logic [3:0] DBS_J_END      = 4'h8;
  // Register byte offsets
  localparam logic [5:0] DBS_REG_CTRL = 6'h00;
  localparam logic [5:0] DBS_REG_ADDR = 6'h04;
  localparam logic [5:0] DBS_REG_MASK = 6'h08;
  localparam logic [5:0] DBS_REG_STAT = 6'h0C;
  localparam logic [1:0] DBS_WIN_WDAT = 2'h1;
  localparam logic [1:0] DBS_WIN_RDAT = 2'h2;
  localparam int DBS_CTRL_GO     = 0;
  localparam int DBS_CTRL_RD     = 1;
  localparam int DBS_CTRL_SINGLE = 2;
  localparam int DBS_CTRL_PLL    = 3;
  localparam int DBS_CTRL_STOP   = 4;
  localparam logic [4:0] DBS_CTRL_RST = 5'h08;
  localparam logic [7:0] DBS_MASK_RST = 8'h00;
  typedef enum logic [2:0] {
    DBS_LOCK = 3'b001,
    DBS_IDLE = 3'b010,
    DBS_RUN  = 3'b100
  } dbs_ctl_st_t;
endpackage

// *** verilog/dbs_link_if.sv ***
// Link between the memory controller and the SRAM port
`timescale 1ns/1ps
interface dbs_link_if #(
  parameter int AW = dbs_pkg::DBS_AW,
  parameter int DW = dbs_pkg::DBS_DW
);
  logic          k;
  logic          k_n;
  logic          c;
  logic          c_n;
  logic          cycle_load_n;
  logic          read_sel;
  logic [AW-1:0] addr;
  logic          low_byte_write_en_n;
  logic          high_byte_write_en_n;
  logic          pll_disable_n;
  logic [DW-1:0] ctl_dq;
  logic          ctl_dq_oe;
  logic [DW-1:0] dev_dq;
  logic          dev_dq_oe;
  logic [1:0]    echo_clock_pair;
  logic [DW-1:0] shared_data_bus;

  // A released bus is shown by both enables low; the wire then carries ctl data
  assign shared_data_bus = dev_dq_oe ? dev_dq : ctl_dq;

  modport ctl (
    output k, k_n, c, c_n, cycle_load_n, read_sel, addr,
    output low_byte_write_en_n, high_byte_write_en_n, pll_disable_n,
    output ctl_dq, ctl_dq_oe,
    input  shared_data_bus, echo_clock_pair
  );
  modport dev (
    input  k, k_n, c, c_n, cycle_load_n, read_sel, addr,
    input  low_byte_write_en_n, high_byte_write_en_n, pll_disable_n,
    input  shared_data_bus,
    output dev_dq, dev_dq_oe, echo_clock_pair
  );
endinterface

// *** verilog/dbs_sram_dev.sv ***
// SRAM end of the link: command decode, burst order, data timing, array
// How it works
// - Burst order steps low two bits, wraps
// - Write words on K,K# of t+1, t+2
// - Read words on C#(t+1),C(t+2),C#(t+2),C(t+3)
// - Output clocks held high: time on K pair
// - Controls on K rise; data on both
// - Data bus high impedance from power-up
// - Byte enables mask each data word
// - Stopped clocks keep outputs unchanged
// - Controller holds PLL on, clocks 20us first
// - PLL needs stable K of 120 MHz+
// - Edge after a load ignores controls
// - Address ignored on NOP and in burst
// - Bus cycle ends after four words
`timescale 1ns/1ps
module dbs_sram_dev
  import dbs_pkg::*;
#(
  parameter int AW = DBS_AW
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  // Link
  dbs_link_if.dev   link,
  // Status
  output logic      burst_active_o,
  output logic      pll_locked_o
);

  localparam int DW = DBS_DW;
  localparam int CW = 2 + AW + 2 + DW;
  localparam int SW = $clog2(DBS_KSTOP_CYC);
  localparam logic [SW-1:0] STOP_LAST = SW'(DBS_KSTOP_CYC - 1);
  localparam logic [11:0]   LOCK_LAST = 12'(DBS_LOCK_CYC - 1);

  typedef struct packed {
    logic [3:0]    clk_m;
    logic [3:0]    clk_s;
    logic [3:0]    clk_p;
    logic [CW-1:0] in_m;
    logic [CW-1:0] in_s;
    logic          pll_m;
    logic          pll_s;
    logic          lc_v;
    logic          lc_rd;
    logic [AW-1:0] lc_a;
    logic          ws1;
    logic          ws2;
    logic [AW-1:0] wa1;
    logic [AW-1:0] wa2;
    logic          rs1;
    logic          rs2;
    logic          rs3;
    logic [AW-1:0] ra1;
    logic [AW-1:0] ra2;
    logic [AW-1:0] ra3;
    logic [DW-1:0] dq;
    logic          dq_oe;
    logic [1:0]    echo;
    logic [SW-1:0] kidle;
    logic [11:0]   lock;
    logic          locked;
  } dbs_dev_st_t;

  dbs_dev_st_t   s;
  dbs_dev_st_t   next_s;
  logic [DW-1:0] mem [2**AW];

  logic [3:0]    rise;
  logic          ld_n;
  logic          rd;
  logic [AW-1:0] a;
  logic [1:0]    bw_n;
  logic [DW-1:0] d;
  logic          single;
  logic          out_a;
  logic          out_b;
  logic          we;
  logic [AW-1:0] wa;
  logic [DW-1:0] wd;
  logic [1:0]    wm_n;

  function automatic logic [AW-1:0] burst_addr(input logic [AW-1:0] base,
                                                input logic [1:0]    idx);
    return {base[AW-1:2], base[1:0] + idx};
  endfunction

  always_comb begin
    next_s = s;
    we     = 1'b0;
    wa     = '0;
    wd     = '0;
    wm_n   = 2'b11;
    // Pins pass two flops; edges come from the second and third stage
    next_s.clk_m = {link.c_n, link.c, link.k_n, link.k};
    next_s.clk_s = s.clk_m;
    next_s.clk_p = s.clk_s;
    next_s.in_m  = {link.cycle_load_n, link.read_sel, link.addr,
                    link.high_byte_write_en_n, link.low_byte_write_en_n,
                    link.shared_data_bus};
    next_s.in_s  = s.in_m;
    next_s.pll_m = link.pll_disable_n;
    next_s.pll_s = s.pll_m;
    rise = s.clk_s & ~s.clk_p;
    {ld_n, rd, a, bw_n, d} = s.in_s;
    single = s.clk_s[DBS_PC] & s.clk_s[DBS_PCN];
    out_a  = single ? rise[DBS_PK] : rise[DBS_PC];
    out_b  = single ? rise[DBS_PKN] : rise[DBS_PCN];

    // Command pipeline advances on K only
    if (rise[DBS_PK]) begin
      next_s.ws2 = s.ws1;
      next_s.wa2 = s.wa1;
      next_s.ws1 = s.lc_v & ~s.lc_rd;
      next_s.wa1 = s.lc_a;
      next_s.rs3 = s.rs2;
      next_s.ra3 = s.ra2;
      next_s.rs2 = s.rs1;
      next_s.ra2 = s.ra1;
      next_s.rs1 = s.lc_v & s.lc_rd;
      next_s.ra1 = s.lc_a;
      // A NOP or the edge right after a load takes nothing
      next_s.lc_v = ~ld_n & ~s.lc_v;
      if (~ld_n && !s.lc_v) begin
        next_s.lc_rd = rd;
        next_s.lc_a  = a;
      end
    end

    // Write data on K of the first and second data cycle, K# after each
    if (rise[DBS_PK] && next_s.ws1) begin
      we = 1'b1;
      wa = burst_addr(next_s.wa1, 2'd0);
    end else if (rise[DBS_PK] && next_s.ws2) begin
      we = 1'b1;
      wa = burst_addr(next_s.wa2, 2'd2);
    end else if (rise[DBS_PKN] && s.ws1) begin
      we = 1'b1;
      wa = burst_addr(s.wa1, 2'd1);
    end else if (rise[DBS_PKN] && s.ws2) begin
      we = 1'b1;
      wa = burst_addr(s.wa2, 2'd3);
    end
    wd   = d;
    wm_n = bw_n;

    // Read data; an idle output edge releases the bus
    if (out_b) begin
      if (next_s.rs1) begin
        next_s.dq    = mem[burst_addr(next_s.ra1, 2'd0)];
        next_s.dq_oe = 1'b1;
      end else if (next_s.rs2) begin
        next_s.dq    = mem[burst_addr(next_s.ra2, 2'd2)];
        next_s.dq_oe = 1'b1;
      end else begin
        next_s.dq_oe = 1'b0;
      end
    end
    if (out_a) begin
      if (next_s.rs2) begin
        next_s.dq    = mem[burst_addr(next_s.ra2, 2'd1)];
        next_s.dq_oe = 1'b1;
      end else if (next_s.rs3) begin
        next_s.dq    = mem[burst_addr(next_s.ra3, 2'd3)];
        next_s.dq_oe = 1'b1;
      end else begin
        next_s.dq_oe = 1'b0;
      end
    end
    // With no clock edges nothing above fires, so outputs hold

    // Echo follows whichever pair times the data; it never stops with dq
    next_s.echo = single ? s.clk_s[1:0] : s.clk_s[3:2];

    // Lock monitor: restarts whenever K stalls or the PLL is disabled
    if (rise[DBS_PK]) begin
      next_s.kidle = '0;
    end else if (s.kidle != STOP_LAST) begin
      next_s.kidle = s.kidle + 1'b1;
    end
    if (s.kidle == STOP_LAST || !s.pll_s) begin
      next_s.lock   = '0;
      next_s.locked = 1'b0;
    end else if (s.lock == LOCK_LAST) begin
      next_s.locked = 1'b1;
    end else begin
      next_s.lock = s.lock + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Array has no reset; each byte lane written only when enabled
  always_ff @(posedge clk_i) begin
    if (we) begin
      if (!wm_n[0]) begin
        mem[wa][DBS_LO_MSB:0] <= wd[DBS_LO_MSB:0];
      end
      if (!wm_n[1]) begin
        mem[wa][DW-1:DBS_HI_LSB] <= wd[DW-1:DBS_HI_LSB];
      end
    end
  end

  assign link.dev_dq          = s.dq;
  assign link.dev_dq_oe       = s.dq_oe;
  assign link.echo_clock_pair = s.echo;
  assign burst_active_o = s.lc_v | s.ws1 | s.ws2 | s.rs1 | s.rs2 | s.rs3;
  assign pll_locked_o   = s.locked;

endmodule

// *** dv/dbs_sram_chk.sv ***
// Link checker for the burst-of-four SRAM port
`timescale 1ns/1ps
module dbs_sram_chk
  import dbs_pkg::*;
#(
  parameter int AW = DBS_AW,
  parameter int DW = DBS_DW
) (
  // Clock and reset
  input wire logic          clk_i,
  input wire logic          arst_n_i,
  // Link clocks and controls
  input wire logic          k,
  input wire logic          k_n,
  input wire logic          c,
  input wire logic          c_n,
  input wire logic          cycle_load_n,
  input wire logic          read_sel,
  input wire logic [AW-1:0] addr,
  input wire logic          low_byte_write_en_n,
  input wire logic          high_byte_write_en_n,
  // Data
  input wire logic [DW-1:0] ctl_dq,
  input wire logic          ctl_dq_oe,
  input wire logic [DW-1:0] dev_dq,
  input wire logic          dev_dq_oe,
  input wire logic [1:0]    echo_clock_pair
);
  logic [3:0] clk_q;
  logic [7:0] rd_cnt;
  logic [7:0] wr_cnt;
  logic [7:0] oe_cnt;
  logic [7:0] still_cnt;

  // Ages saturate so an idle link never satisfies a window
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clk_q     <= 4'h0;
      rd_cnt    <= 8'hFF;
      wr_cnt    <= 8'hFF;
      oe_cnt    <= 8'h00;
      still_cnt <= 8'h00;
    end else begin
      clk_q <= {c_n, c, k_n, k};
      if (k && !clk_q[0] && !cycle_load_n && read_sel) rd_cnt <= 8'h00;
      else if (rd_cnt != 8'hFF) rd_cnt <= rd_cnt + 8'h01;
      if (k && !clk_q[0] && !cycle_load_n && !read_sel) wr_cnt <= 8'h00;
      else if (wr_cnt != 8'hFF) wr_cnt <= wr_cnt + 8'h01;
      if (!dev_dq_oe) oe_cnt <= 8'h00;
      else if (oe_cnt != 8'hFF) oe_cnt <= oe_cnt + 8'h01;
      if ({c_n, c, k_n, k} != clk_q) still_cnt <= 8'h00;
      else if (still_cnt != 8'hFF) still_cnt <= still_cnt + 8'h01;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  AST_NO_CONTENTION: assert property (!(dev_dq_oe && ctl_dq_oe))
    else $error("both ends drive the data bus");
  AST_RD_START: assert property ($rose(dev_dq_oe) |-> rd_cnt >= 8'h14 && rd_cnt <= 8'h28)
    else $error("read data not placed after a read load");
  AST_RD_LEN: assert property (dev_dq_oe |-> oe_cnt <= 8'h28)
    else $error("device drives beyond four words");
  AST_WR_START: assert property ($rose(ctl_dq_oe) |-> wr_cnt >= 8'h06 && wr_cnt <= 8'h12)
    else $error("write data not started after a write load");
  AST_WR_END: assert property ($fell(ctl_dq_oe) |-> wr_cnt >= 8'h26 && wr_cnt <= 8'h32)
    else $error("write data not four words long");
  AST_LOAD_PULSE: assert property ($fell(cycle_load_n) |->
    (!cycle_load_n)[*4] ##[1:12] cycle_load_n)
    else $error("load strobe not a single load");
  AST_CTRL_HOLD: assert property ($rose(k) |->
    $stable(cycle_load_n) && $stable(read_sel) && $stable(addr))
    else $error("controls move at the true clock rise");
  AST_DATA_HOLD: assert property (($rose(k) || $rose(k_n)) && ctl_dq_oe |-> $stable(ctl_dq)
    && $stable(low_byte_write_en_n) && $stable(high_byte_write_en_n))
    else $error("write data or lane enables move at a data edge");
  AST_FROZEN: assert property (still_cnt >= 8'h10 |->
    $stable(dev_dq_oe) && $stable(dev_dq) && $stable(echo_clock_pair))
    else $error("device outputs move while clocks are stopped");
  AST_ECHO: assert property ($past(arst_n_i, 3) |-> echo_clock_pair ==
    (($past(c, 3) && $past(c_n, 3)) ? $past({k_n, k}, 3) : $past({c_n, c}, 3)))
    else $error("echo clocks do not follow the timing clock pair");
endmodule

// *** dv/ddr_burst4_sram_port_test.sv ***
// Bench joining controller and SRAM ends over the link
`timescale 1ns/1ps
module ddr_burst4_sram_port_test
  import dbs_pkg::*;
;
  localparam int TAW = 8;
  logic        clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        busy;
  logic        locked;
  int          miscompares = 0;
  int          check_count = 0;
  int          cyc = 0;
  logic [17:0] em [4];
  logic [31:0] q;

  dbs_link_if #(.AW(TAW)) link ();
  dbs_sram_dev #(.AW(TAW)) dbs_sram_dev_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .link(link), .burst_active_o(busy), .pll_locked_o(locked));
  dbs_sram_ctl #(.AW(TAW)) dbs_sram_ctl_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .link(link), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  dbs_sram_chk #(.AW(TAW)) dbs_sram_chk_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .k(link.k), .k_n(link.k_n), .c(link.c), .c_n(link.c_n),
    .cycle_load_n(link.cycle_load_n), .read_sel(link.read_sel), .addr(link.addr),
    .low_byte_write_en_n(link.low_byte_write_en_n),
    .high_byte_write_en_n(link.high_byte_write_en_n), .ctl_dq(link.ctl_dq),
    .ctl_dq_oe(link.ctl_dq_oe), .dev_dq(link.dev_dq), .dev_dq_oe(link.dev_dq_oe),
    .echo_clock_pair(link.echo_clock_pair));

  always #4 clk_i = ~clk_i;

  task finish_test;
    if (miscompares == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Ceiling covers two relocks plus a handful of bursts
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      $display("[ERR] %0t run timed out", $time);
      finish_test;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Waitrequest and readdata are taken at the rising edge, before it updates them
  task av(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    if (n >= 64) chk(32'h0000_0000, 32'h0000_0001);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      av(1'b0, DBS_REG_STAT, 32'h0000_0000);
      n++;
    end while (q[b] !== v && n < 1500);
    chk({31'h0000_0000, q[b]}, {31'h0000_0000, v});
  endtask

  task go(input logic [1:0] st, input logic rd, input logic sgl, input logic [7:0] m);
    av(1'b1, DBS_REG_ADDR, {24'h00_0000, 6'h05, st});
    av(1'b1, DBS_REG_MASK, {24'h00_0000, m});
    av(1'b1, DBS_REG_CTRL, {27'h000_0000, 1'b0, 1'b1, sgl, rd, 1'b1});
    poll(0, 1'b0);
  endtask

  task wburst(input logic [1:0] st, input logic [7:0] m, input logic [17:0] base);
    logic [17:0] d;
    logic [1:0]  a;
    for (int n = 0; n < 4; n++) begin
      d = base ^ {9{2'(n)}};
      a = st + 2'(n);
      av(1'b1, 6'h10 + 6'(4 * n), {14'h0000, d});
      if (!m[2*n]) em[a][8:0] = d[8:0];
      if (!m[2*n+1]) em[a][17:9] = d[17:9];
    end
    go(st, 1'b0, 1'b0, m);
    chk({31'h0000_0000, busy}, 32'h0000_0000);
  endtask

  task rburst(input logic [1:0] st, input logic sgl);
    go(st, 1'b1, sgl, 8'h00);
    for (int n = 0; n < 4; n++) begin
      av(1'b0, 6'h20 + 6'(4 * n), 32'h0000_0000);
      chk(q, {14'h0000, em[st+2'(n)]});
    end
    chk({31'h0000_0000, busy}, 32'h0000_0000);
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    chk({31'h0000_0000, link.dev_dq_oe}, 32'h0000_0000);
    av(1'b0, DBS_REG_CTRL, 32'h0000_0000);
    chk(q, {27'h000_0000, DBS_CTRL_RST});
    av(1'b0, DBS_REG_MASK, 32'h0000_0000);
    chk(q, {24'h00_0000, DBS_MASK_RST});
    av(1'b1, 6'h3C, 32'hFFFF_FFFF);
    av(1'b0, 6'h3C, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    // Go before the lock period must start nothing
    av(1'b1, DBS_REG_CTRL, 32'h0000_0009);
    av(1'b0, DBS_REG_STAT, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    poll(1, 1'b1);
    wburst(2'h0, 8'h00, 18'h2_5A3C);
    chk({31'h0000_0000, locked}, 32'h0000_0001);
    wburst(2'h2, 8'hE4, 18'h1_C3A5);
    rburst(2'h1, 1'b0);
    chk({31'h0000_0000, link.dev_dq_oe}, 32'h0000_0000);
    rburst(2'h3, 1'b1);
    av(1'b1, DBS_REG_CTRL, 32'h0000_0018);
    repeat (200) @(posedge clk_i);
    chk({31'h0000_0000, locked}, 32'h0000_0000);
    av(1'b0, DBS_REG_STAT, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    av(1'b1, DBS_REG_CTRL, 32'h0000_0008);
    poll(1, 1'b1);
    rburst(2'h0, 1'b0);
    chk({31'h0000_0000, locked}, 32'h0000_0001);
    // Dropping the PLL enable alone must unlock the device
    av(1'b1, DBS_REG_CTRL, 32'h0000_0000);
    repeat (8) @(posedge clk_i);
    chk({31'h0000_0000, locked}, 32'h0000_0000);
    finish_test;
  end
endmodule
